//--- common/emm_pkg.sv
// package for the emulation memory mapper: types, encodings and constants
package emm_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int ADDR_W      = 24;
    localparam int NUM_RANGES  = 8;
    localparam int PAGE_SHIFT  = 8;                  // 256-byte granularity
    localparam int PAGE_W      = ADDR_W - PAGE_SHIFT;
    localparam int SHADOW_W    = 16;
    localparam int SHADOW_N    = 4;

    // ****************************************************************
    // memory types
    // ****************************************************************
    typedef enum logic [2:0] {
        EMM_EMUL_RAM   = 3'h0,
        EMM_EMUL_ROM   = 3'h1,
        EMM_TARGET_RAM = 3'h2,
        EMM_TARGET_ROM = 3'h3,
        EMM_GUARDED    = 3'h4
    } emm_mem_t;

    // ****************************************************************
    // access space qualifiers
    // ****************************************************************
    typedef enum logic [3:0] {
        EMM_FC_NONE      = 4'h0,
        EMM_FC_SUPER     = 4'h1,
        EMM_FC_SUPER_PRG = 4'h2,
        EMM_FC_SUPER_DAT = 4'h3,
        EMM_FC_USER      = 4'h4,
        EMM_FC_USER_PRG  = 4'h5,
        EMM_FC_USER_DAT  = 4'h6,
        EMM_FC_PRG       = 4'h7,
        EMM_FC_DAT       = 4'h8
    } emm_fcq_t;

    // access space line codes (line 2 = supervisor, 1 = program, 0 = data)
    localparam logic [2:0] FC_USER_DAT  = 3'h1;
    localparam logic [2:0] FC_USER_PRG  = 3'h2;
    localparam logic [2:0] FC_SUPER_DAT = 3'h5;
    localparam logic [2:0] FC_SUPER_PRG = 3'h6;

    // ****************************************************************
    // per-range attributes and trace modes
    // ****************************************************************
    typedef enum logic [1:0] {
        EMM_ATTR_NONE     = 2'h0,
        EMM_ATTR_INTERLK  = 2'h1,
        EMM_ATTR_BYTE     = 2'h2,
        EMM_ATTR_COMBINED = 2'h3
    } emm_attr_t;

    typedef enum logic [1:0] {
        EMM_TRACE_BACKGROUND = 2'h0,
        EMM_TRACE_FOREGROUND = 2'h1,
        EMM_TRACE_BOTH       = 2'h2
    } emm_trace_t;

    typedef struct packed {
        logic                enable;
        logic [PAGE_W-1:0]   start_page;
        logic [PAGE_W-1:0]   end_page;
        emm_fcq_t            fcq;
        emm_mem_t            mem;
        emm_attr_t           attr;
    } emm_range_t;

    // bus cycle as seen from the emulation processor
    typedef struct packed {
        logic                valid;
        logic [ADDR_W-1:0]   addr;
        logic [2:0]          fc;
        logic                write;
    } emm_cycle_t;

    // decision for one cycle
    typedef struct packed {
        logic                hit;
        logic [2:0]          index;
        emm_mem_t            mem;
        logic                emul_sel;
        logic                target_sel;
        logic                emul_wr_en;
        logic                target_wr_en;
        logic                interlock;
        logic                byte_wide;
        logic                trace;
    } emm_route_t;

    localparam emm_mem_t DEFAULT_MEM_RST = EMM_TARGET_RAM;

endpackage

//--- rtl/emm_mapper.sv
// emulation memory mapper: range decode, write protection, breaks, trace qualify
module emm_mapper #(
    parameter int NUM_RANGES = emm_pkg::NUM_RANGES
) (
    input  wire logic                                      sys_clk_i,
    input  wire logic                                      rst_n_i,
    input  wire emm_pkg::emm_range_t [NUM_RANGES-1:0]      range_cfg_i,
    input  wire emm_pkg::emm_mem_t                         default_mem_i,
    input  wire logic                                      rom_break_en_i,
    input  wire emm_pkg::emm_trace_t                       trace_mode_i,
    input  wire logic                                      background_i,
    input  wire emm_pkg::emm_cycle_t                       cycle_i,
    input  wire logic                                      data_size_acknowledge_i,
    input  wire logic                                      emul_reset_monitor_entry_i,
    input  wire logic [emm_pkg::SHADOW_N*emm_pkg::SHADOW_W-1:0] shadow_cfg_i,
    output logic                                           route_valid_o,
    output emm_pkg::emm_route_t                            route_o,
    output logic                                           emul_term_o,
    output logic                                           break_req_o,
    output logic                                           sys_load_o,
    output logic [emm_pkg::SHADOW_N*emm_pkg::SHADOW_W-1:0] sys_cfg_o
);

    // ****************************************************************
    // access space qualifier match
    // ****************************************************************
    function automatic logic fc_match(input emm_pkg::emm_fcq_t q, input logic [2:0] fc);
        logic sup;
        logic prg;
        logic dat;
        sup = fc[2];
        prg = (fc[1:0] == 2'h2);
        dat = (fc[1:0] == 2'h1);
        unique case (q)
            emm_pkg::EMM_FC_NONE:      fc_match = 1'b1;
            emm_pkg::EMM_FC_SUPER:     fc_match = sup;
            emm_pkg::EMM_FC_SUPER_PRG: fc_match = (fc == emm_pkg::FC_SUPER_PRG);
            emm_pkg::EMM_FC_SUPER_DAT: fc_match = (fc == emm_pkg::FC_SUPER_DAT);
            emm_pkg::EMM_FC_USER:      fc_match = !sup;
            emm_pkg::EMM_FC_USER_PRG:  fc_match = (fc == emm_pkg::FC_USER_PRG);
            emm_pkg::EMM_FC_USER_DAT:  fc_match = (fc == emm_pkg::FC_USER_DAT);
            emm_pkg::EMM_FC_PRG:       fc_match = prg;
            emm_pkg::EMM_FC_DAT:       fc_match = dat;
            default:                   fc_match = 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // range decode
    // ****************************************************************
    logic [NUM_RANGES-1:0]        hit_vec;
    logic [emm_pkg::PAGE_W-1:0]   page;

    assign page = cycle_i.addr[emm_pkg::ADDR_W-1:emm_pkg::PAGE_SHIFT];

    for (genvar g = 0; g < NUM_RANGES; g++) begin : g_hit
        assign hit_vec[g] = range_cfg_i[g].enable
                         && page >= range_cfg_i[g].start_page
                         && page <= range_cfg_i[g].end_page
                         && fc_match(range_cfg_i[g].fcq, cycle_i.fc);
    end

    emm_pkg::emm_route_t next_route;
    emm_pkg::emm_mem_t   dflt;
    logic                next_break;

    // an emulation type as default falls back to target RAM
    always_comb begin
        dflt = default_mem_i;
        if (default_mem_i == emm_pkg::EMM_EMUL_RAM || default_mem_i == emm_pkg::EMM_EMUL_ROM) begin
            dflt = emm_pkg::DEFAULT_MEM_RST;
        end
    end

    always_comb begin
        emm_pkg::emm_attr_t attr;
        logic               rom;
        attr       = emm_pkg::EMM_ATTR_NONE;
        rom        = 1'b0;
        next_route = '0;
        next_route.mem = dflt;
        // lowest numbered matching range wins
        for (int i = NUM_RANGES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                next_route.hit   = 1'b1;
                next_route.index = 3'(i);
                next_route.mem   = range_cfg_i[i].mem;
                attr             = range_cfg_i[i].attr;
            end
        end
        next_route.emul_sel   = (next_route.mem == emm_pkg::EMM_EMUL_RAM)
                             || (next_route.mem == emm_pkg::EMM_EMUL_ROM);
        next_route.target_sel = (next_route.mem == emm_pkg::EMM_TARGET_RAM)
                             || (next_route.mem == emm_pkg::EMM_TARGET_ROM);
        next_route.emul_wr_en = cycle_i.write
                             && next_route.mem == emm_pkg::EMM_EMUL_RAM;
        next_route.target_wr_en = cycle_i.write && next_route.target_sel;
        next_route.interlock  = next_route.emul_sel
                             && (attr == emm_pkg::EMM_ATTR_INTERLK
                                 || attr == emm_pkg::EMM_ATTR_COMBINED);
        next_route.byte_wide  = next_route.emul_sel
                             && (attr == emm_pkg::EMM_ATTR_BYTE
                                 || attr == emm_pkg::EMM_ATTR_COMBINED);
        unique case (trace_mode_i)
            emm_pkg::EMM_TRACE_BACKGROUND: next_route.trace = background_i;
            emm_pkg::EMM_TRACE_FOREGROUND: next_route.trace = !background_i;
            emm_pkg::EMM_TRACE_BOTH:       next_route.trace = 1'b1;
            default:                       next_route.trace = 1'b0;
        endcase
        rom = (next_route.mem == emm_pkg::EMM_EMUL_ROM)
           || (next_route.mem == emm_pkg::EMM_TARGET_ROM);
        next_break = cycle_i.valid && !background_i
                  && ((next_route.mem == emm_pkg::EMM_GUARDED)
                      || (rom_break_en_i && cycle_i.write && rom));
    end

    // ****************************************************************
    // registered decision
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            route_valid_o <= 1'b0;
            route_o       <= '0;
            break_req_o   <= 1'b0;
        end else begin
            route_valid_o <= cycle_i.valid;
            route_o       <= next_route;
            break_req_o   <= next_break;
        end
    end

    // termination: interlocked cycles wait for the target acknowledge
    assign emul_term_o = route_valid_o && route_o.emul_sel
                      && (!route_o.interlock || data_size_acknowledge_i);

    // ****************************************************************
    // shadow configuration load
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_load_o <= 1'b0;
            sys_cfg_o  <= '0;
        end else begin
            sys_load_o <= emul_reset_monitor_entry_i;
            if (emul_reset_monitor_entry_i) begin
                sys_cfg_o <= shadow_cfg_i;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_rom_break;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cycle_i.valid && !background_i && cycle_i.write && rom_break_en_i
         && (next_route.mem == emm_pkg::EMM_EMUL_ROM || next_route.mem == emm_pkg::EMM_TARGET_ROM))
        |=> break_req_o;
    endproperty
    a_rom_break: assert property (p_rom_break) else $error("rom write missed break");

    property p_emul_rom_protect;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        route_o.mem == emm_pkg::EMM_EMUL_ROM |-> !route_o.emul_wr_en;
    endproperty
    a_emul_rom_protect: assert property (p_emul_rom_protect) else $error("emul rom written");

    property p_target_rom_write;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cycle_i.write && next_route.mem == emm_pkg::EMM_TARGET_ROM) |=> route_o.target_wr_en;
    endproperty
    a_target_rom_write: assert property (p_target_rom_write) else $error("target rom write lost");

    property p_no_break_off;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!rom_break_en_i && next_route.mem != emm_pkg::EMM_GUARDED) |=> !break_req_o;
    endproperty
    a_no_break_off: assert property (p_no_break_off) else $error("break while disabled");

    property p_trace_fg;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (trace_mode_i == emm_pkg::EMM_TRACE_FOREGROUND) |=> (route_o.trace == !$past(background_i));
    endproperty
    a_trace_fg: assert property (p_trace_fg) else $error("foreground trace wrong");

    property p_interlock;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (route_o.interlock && !data_size_acknowledge_i) |-> !emul_term_o;
    endproperty
    a_interlock: assert property (p_interlock) else $error("early termination");

    property p_guarded;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cycle_i.valid && !background_i && next_route.mem == emm_pkg::EMM_GUARDED) |=> break_req_o;
    endproperty
    a_guarded: assert property (p_guarded) else $error("guarded access missed break");

    property p_default_not_emul;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (route_valid_o && !route_o.hit) |-> !route_o.emul_sel;
    endproperty
    a_default_not_emul: assert property (p_default_not_emul) else $error("default is emul");

    property p_shadow_load;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        emul_reset_monitor_entry_i |=> (sys_load_o && sys_cfg_o == $past(shadow_cfg_i));
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("shadow not copied");

    property p_shadow_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !emul_reset_monitor_entry_i |=> (!sys_load_o && $stable(sys_cfg_o));
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("shadow copy moved");

    property p_valid_follow;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_i.valid |=> route_valid_o;
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("bus cycle not decoded");

    property p_hit_index;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cycle_i.valid && hit_vec != '0)
        |=> (route_o.hit && $past(hit_vec[next_route.index]));
    endproperty
    a_hit_index: assert property (p_hit_index) else $error("routed to a missed range");

    property p_lowest_wins;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cycle_i.valid && hit_vec[0]) |=> (route_o.index == 3'h0);
    endproperty
    a_lowest_wins: assert property (p_lowest_wins) else $error("wrong overlap winner");

    property p_no_hit_default;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cycle_i.valid && hit_vec == '0)
        |=> (!route_o.hit && (route_o.mem == $past(default_mem_i)
                              || route_o.mem == emm_pkg::EMM_TARGET_RAM));
    endproperty
    a_no_hit_default: assert property (p_no_hit_default) else $error("no default");

    for (genvar g = 0; g < NUM_RANGES; g++) begin : g_fc_chk
        property p_fc_none;
            @(posedge sys_clk_i) disable iff (!rst_n_i)
            (range_cfg_i[g].enable && range_cfg_i[g].fcq == emm_pkg::EMM_FC_NONE
             && page >= range_cfg_i[g].start_page && page <= range_cfg_i[g].end_page)
            |-> hit_vec[g];
        endproperty
        a_fc_none: assert property (p_fc_none) else $error("unqualified range missed");

        property p_fc_space;
            @(posedge sys_clk_i) disable iff (!rst_n_i)
            ((range_cfg_i[g].fcq == emm_pkg::EMM_FC_SUPER && !cycle_i.fc[2])
             || (range_cfg_i[g].fcq == emm_pkg::EMM_FC_USER && cycle_i.fc[2]))
            |-> !hit_vec[g];
        endproperty
        a_fc_space: assert property (p_fc_space) else $error("range hit in wrong space");
    end

    // attribute bit 1 asks for byte width, bit 0 for the interlock
    property p_byte_attr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (next_route.hit && next_route.emul_sel)
        |=> (route_o.byte_wide == $past(range_cfg_i[next_route.index].attr[1]));
    endproperty
    a_byte_attr: assert property (p_byte_attr) else $error("byte width lost");

    property p_interlock_attr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (next_route.hit && next_route.emul_sel)
        |=> (route_o.interlock == $past(range_cfg_i[next_route.index].attr[0]));
    endproperty
    a_interlock_attr: assert property (p_interlock_attr) else $error("interlock lost");

    property p_trace_bg;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (trace_mode_i == emm_pkg::EMM_TRACE_BACKGROUND)
        |=> (route_o.trace == $past(background_i));
    endproperty
    a_trace_bg: assert property (p_trace_bg) else $error("background trace wrong");

    property p_bg_no_break;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        background_i |=> !break_req_o;
    endproperty
    a_bg_no_break: assert property (p_bg_no_break) else $error("break on monitor cycle");

    c_rom_break:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
                                  break_req_o && route_o.mem == emm_pkg::EMM_EMUL_ROM);
    c_interlock:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
                                  route_o.interlock && emul_term_o);
    c_overlap:    cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
                                  $countones(hit_vec) > 1);
    c_shadow:     cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) sys_load_o);
    c_guarded:    cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
                                  break_req_o && route_o.mem == emm_pkg::EMM_GUARDED);

endmodule

//--- test/emm_target_model.sv
// target side model: answers a held bus cycle with data size acknowledge after a set wait
module emm_target_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       route_valid_i,
    input  wire logic [3:0] wait_i,
    output logic            data_size_acknowledge_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] held;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held <= 4'h0;
        end else if (route_valid_i && held != 4'hf) begin
            held <= held + 4'h1;
        end else if (!route_valid_i) begin
            held <= 4'h0;
        end
    end

    // acknowledge only while a cycle is in progress; zero wait answers at once
    assign data_size_acknowledge_o = route_valid_i && (held >= wait_i);
endmodule

//--- test/emm_mapper_tb_top.sv
// self-checking bench for the emulation memory mapper
module emm_mapper_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk, rst_n, rom_brk, bg, entry, ack, rv, term, brk, load;
    logic [3:0]                wt;
    logic [63:0]               shadow, sys_cfg;
    emm_pkg::emm_range_t [7:0] cfg;
    emm_pkg::emm_mem_t         dflt;
    emm_pkg::emm_trace_t       tmode;
    emm_pkg::emm_cycle_t       cyc_in;
    emm_pkg::emm_route_t       rt;
    int                        err_total, comparisons, ticks;

    emm_mapper u_emm_mapper (
        .sys_clk_i(clk), .rst_n_i(rst_n), .range_cfg_i(cfg), .default_mem_i(dflt),
        .rom_break_en_i(rom_brk), .trace_mode_i(tmode), .background_i(bg), .cycle_i(cyc_in),
        .data_size_acknowledge_i(ack), .emul_reset_monitor_entry_i(entry),
        .shadow_cfg_i(shadow), .route_valid_o(rv), .route_o(rt), .emul_term_o(term),
        .break_req_o(brk), .sys_load_o(load), .sys_cfg_o(sys_cfg));
    emm_target_model u_emm_target_model (
        .sys_clk_i(clk), .rst_n_i(rst_n), .route_valid_i(rv), .wait_i(wt),
        .data_size_acknowledge_o(ack));

    always #25 clk = ~clk;

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic emm_pkg::emm_range_t rng(input logic [15:0] s, input logic [15:0] e,
        input emm_pkg::emm_fcq_t q, input emm_pkg::emm_mem_t m, input emm_pkg::emm_attr_t a);
        rng = '{1'b1, s, e, q, m, a};
    endfunction

    function automatic logic fc_ok(input emm_pkg::emm_fcq_t q, input logic [2:0] fc);
        logic s, p, d;
        s = fc[2];
        p = (fc[1:0] == 2'h2);
        d = (fc[1:0] == 2'h1);
        case (q)
            emm_pkg::EMM_FC_SUPER:     fc_ok = s;
            emm_pkg::EMM_FC_SUPER_PRG: fc_ok = s && p;
            emm_pkg::EMM_FC_SUPER_DAT: fc_ok = s && d;
            emm_pkg::EMM_FC_USER:      fc_ok = !s;
            emm_pkg::EMM_FC_USER_PRG:  fc_ok = !s && p;
            emm_pkg::EMM_FC_USER_DAT:  fc_ok = !s && d;
            emm_pkg::EMM_FC_PRG:       fc_ok = p;
            emm_pkg::EMM_FC_DAT:       fc_ok = d;
            default:                   fc_ok = 1'b1;
        endcase
    endfunction

    // one bus cycle, judged on the registered decision one edge later
    task automatic cyc(input logic [23:0] a, input logic [2:0] fc, input logic wr,
        input emm_pkg::emm_mem_t m, input logic h, input logic [2:0] i, input logic b);
        logic tgt;
        logic emu;
        tgt = m inside {emm_pkg::EMM_TARGET_RAM, emm_pkg::EMM_TARGET_ROM};
        emu = m inside {emm_pkg::EMM_EMUL_RAM, emm_pkg::EMM_EMUL_ROM};
        cyc_in = '{1'b1, a, fc, wr};
        @(negedge clk);
        chk("route_valid", 64'h1, rv);
        chk("mem", m, rt.mem);
        chk("hit", h, rt.hit);
        if (h) chk("index", i, rt.index);
        chk("break", b, brk);
        chk("emul_wr", wr && m == emm_pkg::EMM_EMUL_RAM, rt.emul_wr_en);
        chk("target_wr", wr && tgt, rt.target_wr_en);
        chk("target_sel", tgt, rt.target_sel);
        chk("emul_sel", emu, rt.emul_sel);
        if (h && emu) begin
            chk("interlock", cfg[i].attr[0], rt.interlock);
            chk("byte_wide", cfg[i].attr[1], rt.byte_wide);
        end
    endtask

    // holds a read until termination and counts the cycles it took
    task automatic hold(input logic [23:0] a, input logic [2:0] fc, input logic [3:0] w,
        input int n_exp);
        int n;
        cyc_in.valid = 1'b0;
        wt = w;
        repeat (2) @(negedge clk);
        cyc_in = '{1'b1, a, fc, 1'b0};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (term !== 1'b1 && n < 20);
        chk("term_cycles", n_exp, n);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_fcode;
        logic [2:0] fcs [4];
        logic       e;
        fcs = '{emm_pkg::FC_USER_DAT, emm_pkg::FC_USER_PRG, emm_pkg::FC_SUPER_DAT,
                emm_pkg::FC_SUPER_PRG};
        cyc(24'h003000, emm_pkg::FC_USER_PRG, 1'b1, emm_pkg::EMM_EMUL_RAM, 1, 3'h0, 0);
        cyc(24'h003fff, emm_pkg::FC_USER_DAT, 1'b0, emm_pkg::EMM_EMUL_RAM, 1, 3'h1, 0);
        cyc(24'h003000, emm_pkg::FC_SUPER_PRG, 1'b0, emm_pkg::EMM_TARGET_RAM, 0, 0, 0);
        cyc(24'h004000, emm_pkg::FC_SUPER_DAT, 1'b1, emm_pkg::EMM_TARGET_ROM, 1, 3'h2, 0);
        for (int q = 0; q < 9; q++) begin
            for (int f = 0; f < 4; f++) begin
                cfg[7] = rng(16'h0090, 16'h0090, emm_pkg::emm_fcq_t'(q),
                             emm_pkg::EMM_EMUL_RAM, emm_pkg::EMM_ATTR_NONE);
                e = fc_ok(emm_pkg::emm_fcq_t'(q), fcs[f]);
                cyc(24'h0090ff, fcs[f], 1'b0, e ? emm_pkg::EMM_EMUL_RAM :
                    emm_pkg::EMM_TARGET_RAM, e, 3'h7, 0);
            end
        end
    endtask

    task automatic t_rom;
        for (int e = 0; e < 2; e++) begin
            rom_brk = e[0];
            cyc(24'h007000, emm_pkg::FC_USER_PRG, 1, emm_pkg::EMM_EMUL_ROM, 1, 3'h5, e[0]);
            cyc(24'h004010, emm_pkg::FC_USER_PRG, 1, emm_pkg::EMM_TARGET_ROM, 1, 3'h2, e[0]);
            cyc(24'h006000, emm_pkg::FC_USER_DAT, 0, emm_pkg::EMM_GUARDED, 1, 3'h4, 1);
        end
        bg = 1'b1;
        cyc(24'h006000, emm_pkg::FC_SUPER_DAT, 0, emm_pkg::EMM_GUARDED, 1, 3'h4, 0);
        bg = 1'b0;
    endtask

    task automatic t_dflt;
        rom_brk = 1'b1;
        dflt = emm_pkg::EMM_EMUL_RAM;
        cyc(24'h00f000, emm_pkg::FC_USER_DAT, 1, emm_pkg::EMM_TARGET_RAM, 0, 0, 0);
        dflt = emm_pkg::EMM_TARGET_ROM;
        cyc(24'h00f000, emm_pkg::FC_USER_DAT, 1, emm_pkg::EMM_TARGET_ROM, 0, 0, 1);
        dflt = emm_pkg::EMM_TARGET_RAM;
    endtask

    task automatic t_trace;
        for (int m = 0; m < 3; m++) begin
            for (int b = 0; b < 2; b++) begin
                tmode = emm_pkg::emm_trace_t'(m);
                bg = b[0];
                cyc(24'h00f000, emm_pkg::FC_SUPER_DAT, 0, emm_pkg::EMM_TARGET_RAM, 0, 0, 0);
                chk("trace", m == 2 || (m == 0 && b == 1) || (m == 1 && b == 0), rt.trace);
            end
        end
        bg = 1'b0;
    endtask

    task automatic t_lock;
        hold(24'h003000, emm_pkg::FC_USER_PRG, 4'h3, 4);
        hold(24'h003000, emm_pkg::FC_USER_PRG, 4'h0, 1);
        hold(24'h005000, emm_pkg::FC_SUPER_DAT, 4'h2, 3);
        hold(24'h003000, emm_pkg::FC_USER_DAT, 4'h3, 1);
    endtask

    task automatic t_shadow;
        shadow = 64'h0123456789abcdef;
        entry = 1'b1;
        @(negedge clk);
        entry = 1'b0;
        shadow = 64'hfedcba9876543210;
        chk("sys_load", 64'h1, load);
        chk("sys_cfg", 64'h0123456789abcdef, sys_cfg);
        @(negedge clk);
        chk("sys_load", 64'h0, load);
        chk("sys_cfg", 64'h0123456789abcdef, sys_cfg);
    endtask

    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            err_total++;
            close_out;
        end
    end

    initial begin
        {clk, rst_n, rom_brk, bg, entry, wt, shadow, cfg, cyc_in} = '0;
        {err_total, comparisons, ticks} = '0;
        dflt = emm_pkg::EMM_TARGET_RAM;
        tmode = emm_pkg::EMM_TRACE_BOTH;
        cfg[0] = rng(16'h0030, 16'h003f, emm_pkg::EMM_FC_USER_PRG, emm_pkg::EMM_EMUL_RAM,
                     emm_pkg::EMM_ATTR_INTERLK);
        cfg[1] = rng(16'h0030, 16'h003f, emm_pkg::EMM_FC_USER_DAT, emm_pkg::EMM_EMUL_RAM,
                     emm_pkg::EMM_ATTR_BYTE);
        cfg[2] = rng(16'h0040, 16'h004f, emm_pkg::EMM_FC_NONE, emm_pkg::EMM_TARGET_ROM,
                     emm_pkg::EMM_ATTR_NONE);
        cfg[3] = rng(16'h0050, 16'h0050, emm_pkg::EMM_FC_NONE, emm_pkg::EMM_EMUL_RAM,
                     emm_pkg::EMM_ATTR_COMBINED);
        cfg[4] = rng(16'h0060, 16'h006f, emm_pkg::EMM_FC_NONE, emm_pkg::EMM_GUARDED,
                     emm_pkg::EMM_ATTR_NONE);
        cfg[5] = rng(16'h0070, 16'h007f, emm_pkg::EMM_FC_USER, emm_pkg::EMM_EMUL_ROM,
                     emm_pkg::EMM_ATTR_NONE);
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk("route_valid", 64'h0, rv);
        chk("break", 64'h0, brk);
        t_fcode;
        t_rom;
        t_dflt;
        t_trace;
        t_lock;
        t_shadow;
        close_out;
    end
endmodule
